// File: shared/dac_fifo_pkg.sv
package dac_fifo_pkg;
	// ************************************************
	// register map
	// ************************************************
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_OFFSET = 4'h4;
	localparam logic [3:0] ADDR_SYNCSEL = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'hc;
	localparam int CTRL_FIFO_ENA = 0;
	localparam int CTRL_WORD_WIDE = 1;
	localparam int CTRL_AUTO_RESYNC = 2;
	localparam int CTRL_PLL_PATH = 3;
	localparam int CTRL_PLL_SLEEP = 4;
	localparam int CTRL_INTERP_LSB = 5;
	localparam int CTRL_SIF_SYNC = 8;
	localparam int CTRL_W = 7;
	localparam logic [6:0] CTRL_RESET = 7'h11;
	localparam logic [2:0] OFFSET_RESET = 3'h4;
	localparam int SEL_SYNC = 0;
	localparam int SEL_FRAME = 1;
	localparam int SEL_STROBE = 2;
	localparam int SEL_SIF = 3;
	localparam int WR_SEL_LSB = 0;
	localparam int RD_SEL_LSB = 8;
	localparam logic [4:0] WR_SEL_RESET = 5'h02;
	localparam logic [4:0] RD_SEL_RESET = 5'h04;
	localparam int STAT_ALARM = 0;
	localparam int STAT_WRPTR_LSB = 4;
	localparam int STAT_RDPTR_LSB = 8;
	// ************************************************
	// data path
	// ************************************************
	localparam int DEPTH = 8;
	localparam int PTR_W = 3;
	localparam int SAMPLE_W = 64;
	localparam int LANE_W = 16;
	localparam int BYTE_W = 8;
	localparam int PH_W = 2;
	localparam logic [1:0] PH_LAST = 2'h3;
	localparam logic [2:0] PTR_LAST = 3'h7;
	localparam logic [4:0] INTERP_BASE = 5'h02;
	// pin sampler slots
	localparam int PIN_SYNC = 0;
	localparam int PIN_FRAME = 1;
	localparam int PIN_DDR = 2;
	localparam int PIN_CONV = 3;
	localparam int PIN_STROBE = 4;
endpackage

// File: hw/dac_input_fifo.sv
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module dac_input_fifo
	import dac_fifo_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic [15:0] dataPins,
	input wire logic inputDdrClock,
	input wire logic syncPin,
	input wire logic framePin,
	input wire logic converterClock,
	input wire logic outputStrobeRef,
	output logic [63:0] sampleOut,
	output logic sampleValid,
	output logic collisionAlarm,
	output logic pllEnable,
	output logic pllSleep
);
	// ************************************************
	// registers and state
	// ************************************************
	logic [CTRL_W-1:0] ctrl_reg;
	logic [2:0] offset_reg;
	logic [4:0] wrSel_reg;
	logic [4:0] rdSel_reg;
	logic alarm_reg;
	logic sifPulse_reg;
	logic waitrequest_reg;
	logic [31:0] readdata_reg;
	logic [15:0] dS1_reg;
	logic [15:0] dS2_reg;
	logic [4:0] pinS1_reg;
	logic [4:0] pinS2_reg;
	logic [4:0] pinS3_reg;
	logic [1:0] srcLat_reg;
	logic strLat_reg;
	logic [PH_W-1:0] phase_reg;
	logic [SAMPLE_W-1:0] asm_reg;
	logic [SAMPLE_W-1:0] asmNext;
	logic [SAMPLE_W-1:0] hold_reg;
	logic [SAMPLE_W-1:0] mem_reg [DEPTH];
	logic [PTR_W-1:0] wrPtr_reg;
	logic [PTR_W-1:0] rdPtr_reg;
	logic rdPend_reg;
	logic [3:0] divCnt_reg;
	logic [SAMPLE_W-1:0] sampleOut_reg;
	logic sampleValid_reg;

	logic busWr;
	logic fifoEna;
	logic wordWide;
	logic ddrRise;
	logic ddrEdge;
	logic convRise;
	logic [1:0] syncEdge;
	logic wrSyncEvt;
	logic rdRecap;
	logic strEdge;
	logic [PH_W-1:0] kEff;
	logic writeEvt;
	logic [4:0] interpLim;
	logic rdTick;
	logic [PTR_W-1:0] rdAddr;
	logic collide;
	logic resync;
	logic [31:0] rdVal;

	assign busWr = write && !waitrequest_reg;
	assign fifoEna = ctrl_reg[CTRL_FIFO_ENA];
	assign wordWide = ctrl_reg[CTRL_WORD_WIDE];

	// ************************************************
	// register bus
	// ************************************************
	// one wait cycle: data settles before the master samples it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			waitrequest_reg <= 1'b1;
		end else if ((read || write) && waitrequest_reg) begin
			waitrequest_reg <= 1'b0;
		end else begin
			waitrequest_reg <= 1'b1;
		end
	end

	always_comb begin
		rdVal = 32'h0;
		if (address == ADDR_CTRL) begin
			rdVal[CTRL_W-1:0] = ctrl_reg;
		end else if (address == ADDR_OFFSET) begin
			rdVal[2:0] = offset_reg;
		end else if (address == ADDR_SYNCSEL) begin
			rdVal[WR_SEL_LSB +: 5] = wrSel_reg;
			rdVal[RD_SEL_LSB +: 5] = rdSel_reg;
		end else if (address == ADDR_STATUS) begin
			rdVal[STAT_ALARM] = alarm_reg;
			rdVal[STAT_WRPTR_LSB +: PTR_W] = wrPtr_reg;
			rdVal[STAT_RDPTR_LSB +: PTR_W] = rdPtr_reg;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			readdata_reg <= 32'h0;
		end else if (read && waitrequest_reg) begin
			readdata_reg <= rdVal;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= CTRL_RESET;
			offset_reg <= OFFSET_RESET;
			wrSel_reg <= WR_SEL_RESET;
			rdSel_reg <= RD_SEL_RESET;
		end else if (busWr) begin
			if (address == ADDR_CTRL) begin
				ctrl_reg <= writedata[CTRL_W-1:0];
			end else if (address == ADDR_OFFSET) begin
				offset_reg <= writedata[2:0];
			end else if (address == ADDR_SYNCSEL) begin
				wrSel_reg <= writedata[WR_SEL_LSB +: 5];
				rdSel_reg <= writedata[RD_SEL_LSB +: 5];
			end
		end
	end

	// software sync is a one-cycle strobe, never stored
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sifPulse_reg <= 1'b0;
		end else begin
			sifPulse_reg <= busWr && address == ADDR_CTRL && writedata[CTRL_SIF_SYNC];
		end
	end

	// ************************************************
	// pin sampling
	// ************************************************
	// pins only reach logic after two flops; stage three is the edge history
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dS1_reg <= 16'h0;
			dS2_reg <= 16'h0;
			pinS1_reg <= 5'h0;
			pinS2_reg <= 5'h0;
			pinS3_reg <= 5'h0;
		end else begin
			dS1_reg <= dataPins;
			dS2_reg <= dS1_reg;
			pinS1_reg <= {outputStrobeRef, converterClock, inputDdrClock, framePin, syncPin};
			pinS2_reg <= pinS1_reg;
			pinS3_reg <= pinS2_reg;
		end
	end

	assign ddrRise = pinS2_reg[PIN_DDR] && !pinS3_reg[PIN_DDR];
	assign ddrEdge = pinS2_reg[PIN_DDR] ^ pinS3_reg[PIN_DDR];
	assign convRise = pinS2_reg[PIN_CONV] && !pinS3_reg[PIN_CONV];

	// ************************************************
	// sync sources
	// ************************************************
	// sync and frame are looked at only on input clock rising edges
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			srcLat_reg <= 2'h0;
		end else if (ddrRise) begin
			srcLat_reg <= pinS2_reg[PIN_FRAME:PIN_SYNC];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			strLat_reg <= 1'b0;
		end else if (convRise) begin
			strLat_reg <= pinS2_reg[PIN_STROBE];
		end
	end

	assign syncEdge = {2{ddrRise}} & pinS2_reg[PIN_FRAME:PIN_SYNC] & ~srcLat_reg;
	// all-zero selects mask every selected reset source; a collision resync still resets both sides
	assign wrSyncEvt = (|(syncEdge & wrSel_reg[SEL_FRAME:SEL_SYNC]))
		|| (sifPulse_reg && wrSel_reg[SEL_SIF]);
	assign rdRecap = (|(syncEdge & rdSel_reg[SEL_FRAME:SEL_SYNC]))
		|| (sifPulse_reg && rdSel_reg[SEL_SIF]);
	assign strEdge = convRise && pinS2_reg[PIN_STROBE] && !strLat_reg
		&& rdSel_reg[SEL_STROBE];

	// ************************************************
	// sample assembly
	// ************************************************
	// a write-side sync also marks the first edge of a sample
	assign kEff = wrSyncEvt ? '0 : phase_reg;
	assign writeEvt = ddrEdge && kEff == PH_LAST;

	always_comb begin
		asmNext = asm_reg;
		if (wordWide) begin
			asmNext[SAMPLE_W-1-LANE_W*kEff -: LANE_W] = dS2_reg;
		end else begin
			asmNext[SAMPLE_W-1-BYTE_W*kEff -: BYTE_W] = dS2_reg[15:8];
			asmNext[SAMPLE_W/2-1-BYTE_W*kEff -: BYTE_W] = dS2_reg[7:0];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_reg <= '0;
			asm_reg <= '0;
		end else if (ddrEdge) begin
			phase_reg <= PH_W'(kEff + 2'h1);
			asm_reg <= asmNext;
		end
	end

	// ************************************************
	// storage and write side
	// ************************************************
	generate
		for (genvar i = 0; i < DEPTH; i++) begin : g_entry
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					mem_reg[i] <= '0;
				end else if (writeEvt && fifoEna && wrPtr_reg == PTR_W'(i)) begin
					mem_reg[i] <= asmNext;
				end
			end
		end
	endgenerate

	// bypass keeps the last whole sample for the converter side
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hold_reg <= '0;
		end else if (writeEvt) begin
			hold_reg <= asmNext;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wrPtr_reg <= '0;
		end else if (resync || wrSyncEvt) begin
			wrPtr_reg <= '0;
		end else if (writeEvt) begin
			wrPtr_reg <= PTR_W'(wrPtr_reg + 3'h1);
		end
	end

	// ************************************************
	// read side
	// ************************************************
	// the divider follows the converter clock; PLL multiplication is analog
	assign interpLim = 5'(INTERP_BASE << ctrl_reg[CTRL_INTERP_LSB +: 2]) - 5'h1;
	assign rdTick = convRise && {1'b0, divCnt_reg} == interpLim;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			divCnt_reg <= 4'h0;
		end else if (rdTick) begin
			divCnt_reg <= 4'h0;
		end else if (convRise) begin
			divCnt_reg <= 4'(divCnt_reg + 4'h1);
		end
	end

	// a pending read reset is taken at the next output tick, hence the
	// phase uncertainty of the recaptured path
	assign rdAddr = rdPend_reg ? offset_reg : rdPtr_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdPend_reg <= 1'b0;
		end else if (strEdge || rdRecap || resync) begin
			rdPend_reg <= 1'b1;
		end else if (rdTick) begin
			rdPend_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdPtr_reg <= OFFSET_RESET;
		end else if (rdTick) begin
			rdPtr_reg <= PTR_W'(rdAddr + 3'h1);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sampleOut_reg <= '0;
			sampleValid_reg <= 1'b0;
		end else begin
			sampleValid_reg <= rdTick;
			if (rdTick) begin
				sampleOut_reg <= fifoEna ? mem_reg[rdAddr] : hold_reg;
			end
		end
	end

	// ************************************************
	// collision alarm
	// ************************************************
	// a rate mismatch at the source ends up here
	assign collide = rdTick && writeEvt && fifoEna && rdAddr == wrPtr_reg;
	assign resync = collide && ctrl_reg[CTRL_AUTO_RESYNC];

	// new collision wins over a write-one clear in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			alarm_reg <= 1'b0;
		end else if (collide) begin
			alarm_reg <= 1'b1;
		end else if (busWr && address == ADDR_STATUS && writedata[STAT_ALARM]) begin
			alarm_reg <= 1'b0;
		end
	end

	// ************************************************
	// outputs
	// ************************************************
	assign readdata = readdata_reg;
	assign waitrequest = waitrequest_reg;
	assign sampleOut = sampleOut_reg;
	assign sampleValid = sampleValid_reg;
	assign collisionAlarm = alarm_reg;
	assign pllEnable = ctrl_reg[CTRL_PLL_PATH];
	assign pllSleep = ctrl_reg[CTRL_PLL_SLEEP];

	// ************************************************
	// assertions
	// ************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	property p_wrap;
		writeEvt && !wrSyncEvt && !resync && wrPtr_reg == PTR_LAST |=> wrPtr_reg == 3'h0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("write pointer did not wrap");

	property p_adv;
		writeEvt && !wrSyncEvt && !resync |=> wrPtr_reg == PTR_W'($past(wrPtr_reg) + 3'h1);
	endproperty
	a_adv: assert property (p_adv) else $error("write pointer did not advance");

	property p_wrreset;
		wrSyncEvt |=> wrPtr_reg == 3'h0 && phase_reg == 2'h1 || !$past(ddrEdge);
	endproperty
	a_wrreset: assert property (p_wrreset) else $error("write pointer not reset");

	property p_rdreset;
		rdTick && rdPend_reg |=> rdPtr_reg == PTR_W'($past(offset_reg) + 3'h1);
	endproperty
	a_rdreset: assert property (p_rdreset) else $error("read reset address wrong");

	property p_valid;
		rdTick |=> sampleValid_reg ##1 !sampleValid_reg;
	endproperty
	a_valid: assert property (p_valid) else $error("read tick without one-cycle valid");

	property p_bypass;
		rdTick && !fifoEna |=> sampleOut_reg == $past(hold_reg);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass data not passed");

	property p_strobe;
		strEdge |=> rdPend_reg;
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe did not arm read reset");

	property p_alarm;
		collide |=> alarm_reg && (!ctrl_reg[CTRL_AUTO_RESYNC] || wrPtr_reg == 3'h0);
	endproperty
	a_alarm: assert property (p_alarm) else $error("collision not flagged");

	property p_nosel;
		wrSel_reg == 5'h0 && writeEvt && !resync && wrPtr_reg != PTR_LAST |=> wrPtr_reg != 3'h0;
	endproperty
	a_nosel: assert property (p_nosel) else $error("reset with sources disabled");
endmodule

// File: test/lvds_source_model.sv
`timescale 1ns/1ps
module lvds_source_model (
	input wire logic clk,
	input wire logic dataRun,
	input wire logic convRun,
	input wire logic wordWide,
	output logic [15:0] dataPins,
	output logic inputDdrClock,
	output logic syncPin,
	output logic framePin,
	output logic converterClock,
	output logic outputStrobeRef,
	output int edgeCount
);
	int step;
	int cstep;
	int convEdges;
	int k;
	logic [11:0] n12;
	logic [63:0] smp;
	logic [15:0] lane;

	assign n12 = 12'(edgeCount / 4);
	assign smp = {4'ha, n12, 4'hb, n12, 4'hc, n12, 4'hd, n12};

	// ************************************************
	// data lane: four ddr edges carry one sample
	// ************************************************
	always_comb begin
		k = edgeCount % 4;
		lane[15:8] = smp[63 - 16 * (k / 2) - 8 * (k % 2) -: 8];
		lane[7:0] = smp[31 - 16 * (k / 2) - 8 * (k % 2) -: 8];
		if (wordWide) lane = smp[63 - 16 * k -: 16];
	end

	// data is moved two cycles ahead of each edge so both sit still across it
	always @(posedge clk) begin
		if (!dataRun) begin
			step <= 0;
			edgeCount <= 0;
			inputDdrClock <= 1'b0;
			syncPin <= 1'b0;
			framePin <= 1'b0;
			// idle lanes flip so a late sample would not see stale data
			dataPins <= (dataPins === 16'h5a5a) ? 16'ha5a5 : 16'h5a5a;
		end else begin
			step <= (step == 3) ? 0 : step + 1;
			if (step == 1) begin
				dataPins <= lane;
				syncPin <= (edgeCount % 32) < 2;
				framePin <= (edgeCount % 32) < 2;
			end
			if (step == 3) begin
				inputDdrClock <= ~inputDdrClock;
				edgeCount <= edgeCount + 1;
			end
		end
	end

	// ************************************************
	// converter clock, same rate as the data clock
	// ************************************************
	always @(posedge clk) begin
		if (!convRun) begin
			cstep <= 0;
			convEdges <= 0;
			converterClock <= 1'b0;
			outputStrobeRef <= 1'b1;
		end else begin
			cstep <= (cstep == 3) ? 0 : cstep + 1;
			if (cstep == 3) begin
				converterClock <= ~converterClock;
				if (converterClock) outputStrobeRef <= (convEdges % 16) == 0;
				else convEdges <= convEdges + 1;
			end
		end
	end
endmodule

// File: test/dac_input_fifo_test.sv
`timescale 1ns/1ps
module dac_input_fifo_test;
	import dac_fifo_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] address = 4'h0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest;
	logic [15:0] dataPins;
	logic inputDdrClock, syncPin, framePin, converterClock, outputStrobeRef;
	logic [63:0] sampleOut;
	logic sampleValid, collisionAlarm, pllEnable, pllSleep;
	logic dataRun = 1'b0;
	logic convRun = 1'b0;
	logic wordWide = 1'b0;
	int edgeCount;
	int mismatches = 0;
	int check_count = 0;
	logic [63:0] outs[$];
	logic [31:0] rd;
	logic [2:0] a4A, a4B, a4C, lastA, lastB, lastC;

	always #10 clk = ~clk;
	always @(posedge clk) if (sampleValid === 1'b1) outs.push_back(sampleOut);

	dac_input_fifo i_dac_input_fifo (.clk, .arst_n, .address, .read, .write, .writedata,
		.readdata, .waitrequest, .dataPins, .inputDdrClock, .syncPin, .framePin,
		.converterClock, .outputStrobeRef, .sampleOut, .sampleValid, .collisionAlarm,
		.pllEnable, .pllSleep);
	lvds_source_model i_lvds_source_model (.clk, .dataRun, .convRun, .wordWide, .dataPins,
		.inputDdrClock, .syncPin, .framePin, .converterClock, .outputStrobeRef, .edgeCount);

	// ************************************************
	// shared tasks
	// ************************************************
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// avalon master: request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		address <= a;
		writedata <= d;
		read <= !wr;
		write <= wr;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (waitrequest === 1'b0) break;
		end
		if (n == 50) begin
			mismatches++;
			end_sim();
		end
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	// ************************************************
	// scenarios
	// ************************************************
	task automatic test_regs();
		check({pllEnable, pllSleep}, 2'b01);
		bus(1'b0, ADDR_CTRL, 32'h0);
		check(rd, 32'h11);
		bus(1'b0, ADDR_OFFSET, 32'h0);
		check(rd, 32'h4);
		bus(1'b0, ADDR_SYNCSEL, 32'h0);
		check(rd, 32'h402);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check(rd, 32'h400);
		bus(1'b0, 4'h2, 32'h0);
		check(rd, 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h9);
		repeat (3) @(posedge clk);
		check({pllEnable, pllSleep}, 2'b10);
		$display("test regs done");
	endtask

	// forty samples streamed with both clocks at the same rate
	task automatic stream(input logic ww, input logic ena);
		int i;
		logic [11:0] x;
		// interpolation code 0 keeps the read rate equal to the write rate
		bus(1'b1, ADDR_CTRL, {25'h0, 5'h04, ww, ena});
		outs.delete();
		@(posedge clk);
		wordWide <= ww;
		dataRun <= 1'b1;
		convRun <= 1'b1;
		for (i = 0; i < 4000 && edgeCount < 160; i++) @(posedge clk);
		if (i == 4000) begin
			mismatches++;
			end_sim();
		end
		dataRun <= 1'b0;
		convRun <= 1'b0;
		repeat (8) @(posedge clk);
		check(outs.size(), 40);
		for (i = 12; i < outs.size(); i++) begin
			x = outs[i][11:0];
			check(outs[i], {4'ha, x, 4'hb, x, 4'hc, x, 4'hd, x});
			check(x, outs[i - 1][11:0] + 12'h1);
		end
		if (ena) check(collisionAlarm, 1'b0);
		$display("test stream done");
	endtask

	// read side alone: reads walk the stored samples, strobe at the start
	task automatic conv_only(input logic [2:0] off, output logic [2:0] a4, output logic [2:0] last);
		int j;
		bus(1'b1, ADDR_OFFSET, {29'h0, off});
		repeat (4) @(posedge clk);
		outs.delete();
		convRun <= 1'b1;
		repeat (128) @(posedge clk);
		convRun <= 1'b0;
		repeat (8) @(posedge clk);
		check(outs.size(), 8);
		for (j = 5; j < 8; j++) check(outs[j][2:0], 3'(outs[j - 1][2:0] + 3'h1));
		a4 = outs[4][2:0];
		last = outs[7][2:0];
		$display("test read side done");
	endtask

	// single-sync with offset 0: read and write land on one entry each tick
	task automatic collide();
		int i;
		bus(1'b1, ADDR_OFFSET, 32'h0);
		bus(1'b1, ADDR_SYNCSEL, 32'h202);
		bus(1'b1, ADDR_CTRL, 32'h11);
		@(posedge clk);
		wordWide <= 1'b0;
		dataRun <= 1'b1;
		// converter side four cycles late puts ticks on write cycles
		repeat (4) @(posedge clk);
		convRun <= 1'b1;
		for (i = 0; i < 1000 && edgeCount < 32; i++) @(posedge clk);
		if (i == 1000) begin
			mismatches++;
			end_sim();
		end
		dataRun <= 1'b0;
		convRun <= 1'b0;
		repeat (8) @(posedge clk);
		check(collisionAlarm, 1'b1);
		bus(1'b1, ADDR_STATUS, 32'h1);
		repeat (2) @(posedge clk);
		check(collisionAlarm, 1'b0);
		bus(1'b1, ADDR_SYNCSEL, 32'h402);
		$display("test collision done");
	endtask

	initial begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		test_regs();
		stream(1'b0, 1'b0);
		stream(1'b1, 1'b1);
		stream(1'b0, 1'b1);
		collide();
		conv_only(3'h6, a4A, lastA);
		conv_only(3'h1, a4B, lastB);
		check(a4B, 3'(a4A + 3'h3));
		bus(1'b1, ADDR_SYNCSEL, 32'h0);
		conv_only(3'h6, a4C, lastC);
		check(a4C, 3'(lastB + 3'h5));
		end_sim();
	end
endmodule
